// ==== hw/fspr_defs.vh ====
// Command codes, field positions and timing counts for the fault pin status block
`ifndef FSPR_DEFS_VH
`define FSPR_DEFS_VH
// ==========================================================
// Command codes
`define FSPR_CMD_CLEAR 8'h03
`define FSPR_CMD_SUM_BYTE 8'h78
`define FSPR_CMD_SUM_WORD 8'h79
`define FSPR_CMD_VOUT 8'h7A
`define FSPR_CMD_IOUT 8'h7B
`define FSPR_CMD_INPUT 8'h7C
`define FSPR_CMD_TEMP 8'h7D
`define FSPR_CMD_CML 8'h7E
`define FSPR_CMD_VENDOR 8'h80
`define FSPR_CMD_SEL0 8'hD5
`define FSPR_CMD_SEL1 8'hD6
`define FSPR_CMD_PADS 8'hE5
`define FSPR_CMD_COMMON 8'hEF
// ==========================================================
// Pages and reset values
`define FSPR_PAGE_ALL 8'hFF
`define FSPR_SEL_RST 4'h0
`define FSPR_PAD_RST 16'h0000
// ==========================================================
// Field positions
`define FSPR_VOUT_OV_BIT 7
`define FSPR_IOUT_OC_BIT 7
`define FSPR_VIN_UV_BIT 4
`define FSPR_VND_PIN0_BIT 0
`define FSPR_VND_PIN1_BIT 1
// ==========================================================
// Timing: qualification time in ns, clock period in ns
`define FSPR_QUAL_NS 10000
`define FSPR_CLK_NS 25
`define FSPR_QUAL_CYC ((`FSPR_QUAL_NS + `FSPR_CLK_NS - 1) / `FSPR_CLK_NS)
`define FSPR_QCNT_W 9
`endif

// ==== hw/fspr_sticky.v ====
// Sticky status flag bank with set winning over clear
`timescale 1ns/1ps
module fspr_sticky #(
   parameter W = 8
) (
   input wire sys_clk,
   input wire rst,
   input wire [W-1:0] set_in,
   input wire clr,
   output reg [W-1:0] flags_ff
);
   // ==========================================================
   // Flag storage
   wire [W-1:0] nxt_flags;
   // A fault still present re-sets its bit right after a clear
   assign nxt_flags = set_in | (clr ? {W{1'b0}} : flags_ff);
   always @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         flags_ff <= {W{1'b0}};
      end else begin
         flags_ff <= nxt_flags;
      end
   end
endmodule // fspr_sticky

// ==== hw/fspr_pin_qual.v ====
// Synchroniser and low-time qualifier for one shared fault pin
`timescale 1ns/1ps
`include "fspr_defs.vh"
module fspr_pin_qual (
   input wire sys_clk,
   input wire rst,
   input wire pin_in_n,
   output reg qual_ff
);
   // ==========================================================
   // Two-stage synchroniser; only the second stage is read
   reg meta_ff;
   reg sync_n_ff;
   always @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         meta_ff <= 1'b1;
         sync_n_ff <= 1'b1;
      end else begin
         meta_ff <= pin_in_n;
         sync_n_ff <= meta_ff;
      end
   end
   // ==========================================================
   // Low-time counter, restarted on every release
   // Cut to the counter width on purpose; the count fits in nine bits
   localparam integer QUAL_INT = `FSPR_QUAL_CYC;
   localparam [`FSPR_QCNT_W-1:0] QUAL_LAST = QUAL_INT[`FSPR_QCNT_W-1:0] - 1'b1;
   reg [`FSPR_QCNT_W-1:0] cnt_ff;
   reg [`FSPR_QCNT_W-1:0] nxt_cnt;
   reg nxt_qual;
   always @* begin
      nxt_cnt = cnt_ff;
      nxt_qual = qual_ff;
      if (sync_n_ff) begin
         nxt_cnt = {`FSPR_QCNT_W{1'b0}};
         nxt_qual = 1'b0;
      end else if (cnt_ff == QUAL_LAST) begin
         nxt_qual = 1'b1;
      end else begin
         nxt_cnt = cnt_ff + 1'b1;
      end
   end
   always @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         cnt_ff <= {`FSPR_QCNT_W{1'b0}};
         qual_ff <= 1'b0;
      end else begin
         cnt_ff <= nxt_cnt;
         qual_ff <= nxt_qual;
      end
   end
endmodule // fspr_pin_qual

// ==== hw/fspr_top.v ====
// Shared fault pin response and fault/warning status command set
`timescale 1ns/1ps
`include "fspr_defs.vh"
// Summary of operation
// - Selected channel shuts down only if pin still low after 10 us.
// - Channel turns back on when pin releases, via sequencer delays.
// - Response bit zero: pin assertion is ignored for that channel.
// - Pin-caused shutdown pulls alert low and sets vendor status flag.
// - Two response registers; bit n selects channel n, channels 3..0.
// - Upper four response bits read as zero, writes ignored.
// - Clear command wipes unpaged flags and selected page flags.
// - Clear command releases the alert contribution at once.
// - Clear command never restarts a latched-off channel.
// - Fault still present after clear sets bit and alert again.
// - Clear with global page acts on all pages.
// - Summary byte: busy, off, ov, oc, vin uv, temp, cml, other.
// - Paged summary word; low byte equals summary byte.
// - Paged voltage and current flag bytes for selected channel.
// - Unpaged input supply flag byte.
// - Unpaged communication and memory flag byte.
// - Paged external temperature flag byte.
// - Paged vendor fault and state flag byte.
// - Unpaged read/write word reporting digital pad states.
// - Unpaged read byte of common vendor status bits.
// - Response registers unpaged read/write bytes, default zero.
// - Off flag set whenever channel is not delivering power.
module fspr_top (
   input wire sys_clk,
   input wire rst,
   // Shared fault pins, active low, asynchronous
   input wire shared_fault_pin_0_n,
   input wire shared_fault_pin_1_n,
   // Host alert line, open drain
   input wire host_alert_line_in_n,
   output wire host_alert_line_out_n,
   output wire host_alert_line_oe,
   // Command port from the bus engine
   input wire cmd_valid,
   input wire cmd_write,
   input wire [7:0] cmd_code,
   input wire [15:0] cmd_wdata,
   input wire [7:0] page_sel,
   output reg cmd_done_ff,
   output reg cmd_err_ff,
   output reg [15:0] cmd_rdata_ff,
   // Fault sources, levels, one bit per flag
   input wire [31:0] vout_fault,
   input wire [31:0] iout_fault,
   input wire [31:0] temp_fault,
   input wire [31:0] vendor_fault,
   input wire [7:0] input_fault,
   input wire [7:0] cml_fault,
   input wire [7:0] common_state,
   input wire [3:0] chan_power_on,
   input wire [3:0] power_not_good,
   input wire busy,
   // Pads, asynchronous
   input wire [15:0] pad_state,
   output reg [15:0] pad_ctrl_ff,
   // Channel control towards the sequencer
   output wire [3:0] chan_pin_shutdown,
   output reg [3:0] chan_restart_ff
);
   // ==========================================================
   // Fault pin qualification
   wire pin0_qual;
   wire pin1_qual;
   fspr_pin_qual u_pin0 (
      .sys_clk(sys_clk),
      .rst(rst),
      .pin_in_n(shared_fault_pin_0_n),
      .qual_ff(pin0_qual)
   );
   fspr_pin_qual u_pin1 (
      .sys_clk(sys_clk),
      .rst(rst),
      .pin_in_n(shared_fault_pin_1_n),
      .qual_ff(pin1_qual)
   );

   // ==========================================================
   // Response registers, only four bits are stored
   reg [3:0] pin0_sel_ff;
   reg [3:0] pin1_sel_ff;
   wire wr_strobe;
   assign wr_strobe = cmd_valid & cmd_write;
   always @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         pin0_sel_ff <= `FSPR_SEL_RST;
         pin1_sel_ff <= `FSPR_SEL_RST;
         pad_ctrl_ff <= `FSPR_PAD_RST;
      end else if (wr_strobe) begin
         if (cmd_code == `FSPR_CMD_SEL0) begin
            pin0_sel_ff <= cmd_wdata[3:0];
         end else if (cmd_code == `FSPR_CMD_SEL1) begin
            pin1_sel_ff <= cmd_wdata[3:0];
         end else if (cmd_code == `FSPR_CMD_PADS) begin
            pad_ctrl_ff <= cmd_wdata;
         end
      end
   end

   // ==========================================================
   // Per-channel shutdown; a zero select bit masks the pin
   wire [3:0] shut_p0;
   wire [3:0] shut_p1;
   reg [3:0] shut_p0_ff;
   reg [3:0] shut_p1_ff;
   assign shut_p0 = {4{pin0_qual}} & pin0_sel_ff;
   assign shut_p1 = {4{pin1_qual}} & pin1_sel_ff;
   // Held only while a pin stays qualified, so clearing flags cannot restart
   assign chan_pin_shutdown = shut_p0_ff | shut_p1_ff;
   always @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         shut_p0_ff <= 4'h0;
         shut_p1_ff <= 4'h0;
         chan_restart_ff <= 4'h0;
      end else begin
         shut_p0_ff <= shut_p0;
         shut_p1_ff <= shut_p1;
         // Restart pulse on release; sequencer applies turn-on delay and rise
         chan_restart_ff <= chan_pin_shutdown & ~(shut_p0 | shut_p1);
      end
   end
   // ==========================================================
   // Clear decoding: unpaged always, paged by page or global page
   wire clr_cmd;
   wire page_all;
   reg [3:0] page_hit;
   assign clr_cmd = wr_strobe & (cmd_code == `FSPR_CMD_CLEAR);
   assign page_all = (page_sel == `FSPR_PAGE_ALL);
   always @* begin
      page_hit = 4'h0;
      if (page_all) begin
         page_hit = 4'hF;
      end else if (page_sel < 8'h04) begin
         page_hit[page_sel[1:0]] = 1'b1;
      end
   end
   wire [3:0] clr_chan;
   assign clr_chan = {4{clr_cmd}} & page_hit;

   // ==========================================================
   // Paged flag banks
   wire [31:0] vout_flags;
   wire [31:0] iout_flags;
   wire [31:0] temp_flags;
   wire [31:0] vnd_flags;
   wire [31:0] vnd_set;
   genvar g;
   generate
      for (g = 0; g < 4; g = g + 1) begin : g_chan
         // Held pin shutdowns feed the vendor byte, so a clear cannot hide them
         assign vnd_set[g*8 +: 8] = vendor_fault[g*8 +: 8]
            | ({7'h00, shut_p0[g]} << `FSPR_VND_PIN0_BIT)
            | ({7'h00, shut_p1[g]} << `FSPR_VND_PIN1_BIT);
         fspr_sticky #(.W(8)) u_vout (
            .sys_clk(sys_clk),
            .rst(rst),
            .set_in(vout_fault[g*8 +: 8]),
            .clr(clr_chan[g]),
            .flags_ff(vout_flags[g*8 +: 8])
         );
         fspr_sticky #(.W(8)) u_iout (
            .sys_clk(sys_clk),
            .rst(rst),
            .set_in(iout_fault[g*8 +: 8]),
            .clr(clr_chan[g]),
            .flags_ff(iout_flags[g*8 +: 8])
         );
         fspr_sticky #(.W(8)) u_temp (
            .sys_clk(sys_clk),
            .rst(rst),
            .set_in(temp_fault[g*8 +: 8]),
            .clr(clr_chan[g]),
            .flags_ff(temp_flags[g*8 +: 8])
         );
         fspr_sticky #(.W(8)) u_vnd (
            .sys_clk(sys_clk),
            .rst(rst),
            .set_in(vnd_set[g*8 +: 8]),
            .clr(clr_chan[g]),
            .flags_ff(vnd_flags[g*8 +: 8])
         );
      end
   endgenerate

   // ==========================================================
   // Unpaged flag banks
   wire [7:0] input_flags;
   wire [7:0] cml_flags;
   fspr_sticky #(.W(8)) u_input (
      .sys_clk(sys_clk),
      .rst(rst),
      .set_in(input_fault),
      .clr(clr_cmd),
      .flags_ff(input_flags)
   );
   fspr_sticky #(.W(8)) u_cml (
      .sys_clk(sys_clk),
      .rst(rst),
      .set_in(cml_fault),
      .clr(clr_cmd),
      .flags_ff(cml_flags)
   );

   // ==========================================================
   // Alert: any new or persisting fault notifies; clear releases
   wire any_set;
   reg alert_ff;
   assign any_set = (|vout_fault) | (|iout_fault) | (|temp_fault) | (|vnd_set)
      | (|input_fault) | (|cml_fault);
   always @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         alert_ff <= 1'b0;
      end else if (any_set) begin
         alert_ff <= 1'b1;
      end else if (clr_cmd) begin
         alert_ff <= 1'b0;
      end
   end
   // Open drain: drive low only while asserting
   assign host_alert_line_out_n = 1'b0;
   assign host_alert_line_oe = alert_ff;

   // ==========================================================
   // Pad synchroniser; only the second stage is read
   reg [15:0] pad_meta_ff;
   reg [15:0] pad_sync_ff;
   always @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         pad_meta_ff <= 16'h0000;
         pad_sync_ff <= 16'h0000;
      end else begin
         pad_meta_ff <= pad_state;
         pad_sync_ff <= pad_meta_ff;
      end
   end

   // ==========================================================
   // Summary word of one channel
   function [15:0] sum_word;
      input [7:0] v;
      input [7:0] i;
      input [7:0] t;
      input [7:0] m;
      input [7:0] inp;
      input [7:0] cml;
      input off;
      input bsy;
      input pgn;
      begin
         // Low byte doubles as the summary byte
         sum_word = {|v, |i, |inp, |m, pgn, 3'b000,
            bsy, off, v[`FSPR_VOUT_OV_BIT], i[`FSPR_IOUT_OC_BIT],
            inp[`FSPR_VIN_UV_BIT], |t, |cml, |m};
      end
   endfunction

   // ==========================================================
   // Selected channel view; invalid page falls back to channel 0
   wire [1:0] ch;
   wire [3:0] chan_off;
   wire [15:0] word_sel;
   assign ch = (page_sel < 8'h04) ? page_sel[1:0] : 2'b00;
   // Off covers pin shutdown and any other reason for no power
   assign chan_off = ~chan_power_on | chan_pin_shutdown;
   assign word_sel = sum_word(vout_flags[ch*8 +: 8], iout_flags[ch*8 +: 8],
      temp_flags[ch*8 +: 8], vnd_flags[ch*8 +: 8], input_flags, cml_flags,
      chan_off[ch], busy, power_not_good[ch]);

   // ==========================================================
   // Read decode
   reg [15:0] nxt_rdata;
   reg nxt_err;
   always @* begin
      nxt_rdata = 16'h0000;
      nxt_err = 1'b0;
      if (cmd_code == `FSPR_CMD_SUM_BYTE) begin
         nxt_rdata = {8'h00, word_sel[7:0]};
      end else if (cmd_code == `FSPR_CMD_SUM_WORD) begin
         nxt_rdata = word_sel;
      end else if (cmd_code == `FSPR_CMD_VOUT) begin
         nxt_rdata = {8'h00, vout_flags[ch*8 +: 8]};
      end else if (cmd_code == `FSPR_CMD_IOUT) begin
         nxt_rdata = {8'h00, iout_flags[ch*8 +: 8]};
      end else if (cmd_code == `FSPR_CMD_INPUT) begin
         nxt_rdata = {8'h00, input_flags};
      end else if (cmd_code == `FSPR_CMD_TEMP) begin
         nxt_rdata = {8'h00, temp_flags[ch*8 +: 8]};
      end else if (cmd_code == `FSPR_CMD_CML) begin
         nxt_rdata = {8'h00, cml_flags};
      end else if (cmd_code == `FSPR_CMD_VENDOR) begin
         nxt_rdata = {8'h00, vnd_flags[ch*8 +: 8]};
      end else if (cmd_code == `FSPR_CMD_SEL0) begin
         nxt_rdata = {12'h000, pin0_sel_ff};
      end else if (cmd_code == `FSPR_CMD_SEL1) begin
         nxt_rdata = {12'h000, pin1_sel_ff};
      end else if (cmd_code == `FSPR_CMD_PADS) begin
         nxt_rdata = pad_sync_ff;
      end else if (cmd_code == `FSPR_CMD_COMMON) begin
         nxt_rdata = {8'h00, common_state};
      end else begin
         nxt_err = 1'b1;
      end
   end

   // ==========================================================
   // Writes accepted only for writable codes
   reg wr_ok;
   always @* begin
      wr_ok = 1'b0;
      if (cmd_code == `FSPR_CMD_CLEAR) begin
         wr_ok = 1'b1;
      end else if (cmd_code == `FSPR_CMD_SEL0) begin
         wr_ok = 1'b1;
      end else if (cmd_code == `FSPR_CMD_SEL1) begin
         wr_ok = 1'b1;
      end else if (cmd_code == `FSPR_CMD_PADS) begin
         wr_ok = 1'b1;
      end
   end

   // ==========================================================
   // Answer: one cycle after the request, data held until next
   always @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         cmd_done_ff <= 1'b0;
         cmd_err_ff <= 1'b0;
         cmd_rdata_ff <= 16'h0000;
      end else begin
         cmd_done_ff <= cmd_valid;
         if (cmd_valid) begin
            if (cmd_write) begin
               cmd_err_ff <= ~wr_ok;
            end else begin
               cmd_err_ff <= nxt_err;
               cmd_rdata_ff <= nxt_rdata;
            end
         end else begin
            cmd_err_ff <= 1'b0;
         end
      end
   end
endmodule // fspr_top

// ==== testbench/fspr_props.sv ====
// Port-level assertions for the fault pin status block
`timescale 1ns/1ps
module fspr_props (
   input wire sys_clk,
   input wire rst,
   input wire shared_fault_pin_0_n,
   input wire shared_fault_pin_1_n,
   input wire host_alert_line_oe,
   input wire cmd_valid,
   input wire cmd_write,
   input wire [7:0] cmd_code,
   input wire cmd_done_ff,
   input wire cmd_err_ff,
   input wire [15:0] cmd_rdata_ff,
   input wire [3:0] chan_pin_shutdown,
   input wire [3:0] chan_restart_ff
);
   reg [9:0] lo0_ff;
   reg [9:0] lo1_ff;
   wire [9:0] nxt_lo0 = shared_fault_pin_0_n ? 10'h000 : lo0_ff + {9'h000, ~&lo0_ff};
   wire [9:0] nxt_lo1 = shared_fault_pin_1_n ? 10'h000 : lo1_ff + {9'h000, ~&lo1_ff};
   wire rd_req = cmd_valid & ~cmd_write;
   // ==========================================================
   // Raw low time per pin; saturates so a long hold never wraps
   always @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         lo0_ff <= 10'h000;
         lo1_ff <= 10'h000;
      end else begin
         lo0_ff <= nxt_lo0;
         lo1_ff <= nxt_lo1;
      end
   end
   // ==========================================================
   // Assertions
   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (rst);
   property p_done;
      cmd_done_ff == $past(cmd_valid);
   endproperty
   a_done: assert property (p_done) else $error("answer strobe off its cycle");
   property p_qual;
      $rose(|chan_pin_shutdown) |-> (lo0_ff >= 10'h190 || lo1_ff >= 10'h190);
   endproperty
   a_qual: assert property (p_qual) else $error("shutdown too early");
   property p_alert;
      $rose(|chan_pin_shutdown) |-> host_alert_line_oe;
   endproperty
   a_alert: assert property (p_alert) else $error("shutdown without alert");
   property p_restart;
      |($past(chan_pin_shutdown) & ~chan_pin_shutdown) |-> ##[0:1] |chan_restart_ff;
   endproperty
   a_restart: assert property (p_restart) else $error("no restart after release");
   property p_pulse;
      |chan_restart_ff |=> chan_restart_ff == 4'h0;
   endproperty
   a_pulse: assert property (p_pulse) else $error("restart longer than one cycle");
   property p_keep;
      cmd_valid && cmd_write && cmd_code == 8'h03 && !shared_fault_pin_0_n
         && !shared_fault_pin_1_n |=> ($past(chan_pin_shutdown) & ~chan_pin_shutdown) == 4'h0;
   endproperty
   a_keep: assert property (p_keep) else $error("clear restarted a channel");
   property p_refuse;
      rd_req && cmd_code == 8'h20 |=> cmd_err_ff && cmd_rdata_ff == 16'h0000;
   endproperty
   a_refuse: assert property (p_refuse) else $error("unmapped read not refused");
   property p_resv;
      rd_req && (cmd_code == 8'hD5 || cmd_code == 8'hD6) |=> cmd_rdata_ff[15:4] == 12'h000;
   endproperty
   a_resv: assert property (p_resv) else $error("select upper bits not zero");
   property p_byte;
      rd_req && cmd_code == 8'h78 |=> !cmd_err_ff && cmd_rdata_ff[15:8] == 8'h00;
   endproperty
   a_byte: assert property (p_byte) else $error("summary byte read wrong");
endmodule // fspr_props

// ==== testbench/fspr_peer.sv ====
// Peer managers on the shared fault pins and the host alert wire
`timescale 1ns/1ps
module fspr_peer (
   input wire [1:0] pull_req,
   input wire alert_oe,
   input wire alert_out_n,
   output wire pin0_n,
   output wire pin1_n,
   output wire alert_n
);
   // ==========================================================
   // Open-drain wires with pull-ups: a released wire reads high
   assign pin0_n = ~pull_req[0];
   assign pin1_n = ~pull_req[1];
   assign alert_n = alert_oe ? alert_out_n : 1'b1;
endmodule // fspr_peer

// ==== testbench/tb.sv ====
// Self-checking bench for the fault pin status block
`timescale 1ns/1ps
module tb;
   reg sys_clk = 1'b0;
   reg rst = 1'b1;
   reg cmd_valid = 1'b0, cmd_write = 1'b0, busy = 1'b0;
   reg [1:0] pull_req = 2'h0;
   reg [7:0] cmd_code = 8'h00, page_sel = 8'h00, input_fault = 8'h00, cml_fault = 8'h00;
   reg [7:0] common_state = 8'h00;
   reg [3:0] chan_power_on = 4'hF, power_not_good = 4'h0;
   reg [15:0] cmd_wdata = 16'h0000, pad_state = 16'h0000;
   reg [31:0] vout_fault = 32'h0, iout_fault = 32'h0, temp_fault = 32'h0, vendor_fault = 32'h0;
   wire cmd_done_ff, cmd_err_ff, host_alert_line_oe, host_alert_line_out_n;
   wire host_alert_line_in_n, shared_fault_pin_0_n, shared_fault_pin_1_n;
   wire [15:0] cmd_rdata_ff, pad_ctrl_ff;
   wire [3:0] chan_pin_shutdown, chan_restart_ff;
   integer miscompares = 0;
   integer check_count = 0;
   logic [15:0] rd;
   logic er;
   // ==========================================================
   // Clock and instances
   always #12.5 sys_clk = ~sys_clk;
   fspr_peer u_peer (.pull_req(pull_req), .alert_oe(host_alert_line_oe),
      .alert_out_n(host_alert_line_out_n), .pin0_n(shared_fault_pin_0_n),
      .pin1_n(shared_fault_pin_1_n), .alert_n(host_alert_line_in_n));
   fspr_top u_dut (.sys_clk, .rst, .shared_fault_pin_0_n, .shared_fault_pin_1_n,
      .host_alert_line_in_n, .host_alert_line_out_n, .host_alert_line_oe, .cmd_valid,
      .cmd_write, .cmd_code, .cmd_wdata, .page_sel, .cmd_done_ff, .cmd_err_ff, .cmd_rdata_ff,
      .vout_fault, .iout_fault, .temp_fault, .vendor_fault, .input_fault, .cml_fault,
      .common_state, .chan_power_on, .power_not_good, .busy, .pad_state, .pad_ctrl_ff,
      .chan_pin_shutdown, .chan_restart_ff);
   // ==========================================================
   // Shared tasks
   task chk(input string what, input logic [15:0] exp, input logic [15:0] got);
      begin
         check_count = check_count + 1;
         if (got !== exp) begin
            miscompares = miscompares + 1;
            $display("BAD %s expected %h seen %h", what, exp, got);
         end
      end
   endtask
   // One request; the answer is taken one cycle later
   task cmd(input logic wr, input logic [7:0] code, input logic [15:0] wd);
      begin
         @(posedge sys_clk);
         cmd_valid <= 1'b1;
         cmd_write <= wr;
         cmd_code <= code;
         cmd_wdata <= wd;
         @(posedge sys_clk);
         cmd_valid <= 1'b0;
         @(negedge sys_clk);
         chk("done", 16'h0001, {15'h0, cmd_done_ff});
         rd = cmd_rdata_ff;
         er = cmd_err_ff;
      end
   endtask
   task rdc(input logic [7:0] code, input logic [15:0] exp);
      begin
         cmd(1'b0, code, 16'h0000);
         chk($sformatf("err %h", code), 16'h0000, {15'h0, er});
         chk($sformatf("data %h", code), exp, rd);
      end
   endtask
   task wrc(input logic [7:0] code, input logic [15:0] wd);
      begin
         cmd(1'b1, code, wd);
         chk($sformatf("err %h", code), 16'h0000, {15'h0, er});
      end
   endtask
   task pg(input logic [7:0] p);
      begin
         @(posedge sys_clk);
         page_sel <= p;
      end
   endtask
   // ==========================================================
   // Scenarios
   task t_select;
      begin
         chk("alert idle", 16'h0000, {15'h0, host_alert_line_oe});
         rdc(8'hD5, 16'h0000);
         rdc(8'hD6, 16'h0000);
         wrc(8'hD5, 16'h00FF);
         rdc(8'hD5, 16'h000F);
         wrc(8'hD6, 16'h00A6);
         rdc(8'hD6, 16'h0006);
         cmd(1'b0, 8'h20, 16'h0000);
         chk("err unmapped", 16'h0001, {15'h0, er});
         cmd(1'b1, 8'h78, 16'h00FF);
         chk("err read only", 16'h0001, {15'h0, er});
         @(posedge sys_clk);
         pad_state <= 16'hC35A;
         repeat (4) @(posedge sys_clk);
         rdc(8'hE5, 16'hC35A);
         wrc(8'hE5, 16'h3C96);
         chk("pad ctrl", 16'h3C96, pad_ctrl_ff);
      end
   endtask
   task t_status;
      begin
         @(posedge sys_clk);
         page_sel <= 8'h01;
         chan_power_on <= 4'hD;
         power_not_good <= 4'h2;
         busy <= 1'b1;
         common_state <= 8'h5A;
         vout_fault <= 32'h0000_8000;
         iout_fault <= 32'h0080_0000;
         temp_fault <= 32'h0000_0100;
         input_fault <= 8'h10;
         cml_fault <= 8'h02;
         repeat (2) @(posedge sys_clk);
         iout_fault <= 32'h0;
         temp_fault <= 32'h0;
         input_fault <= 8'h00;
         cml_fault <= 8'h00;
         rdc(8'h7A, 16'h0080);
         rdc(8'h7D, 16'h0001);
         rdc(8'h79, 16'hA8EE);
         rdc(8'h78, 16'h00EE);
         rdc(8'h7E, 16'h0002);
         rdc(8'hEF, 16'h005A);
         rdc(8'h80, 16'h0000);
         pg(8'h00);
         rdc(8'h7C, 16'h0010);
         rdc(8'h7A, 16'h0000);
         wrc(8'h03, 16'h0000);
         rdc(8'h7E, 16'h0000);
         pg(8'h02);
         rdc(8'h7B, 16'h0080);
         pg(8'h01);
         wrc(8'h03, 16'h0000);
         chk("alert refire", 16'h0001, {15'h0, host_alert_line_oe});
         rdc(8'h7A, 16'h0080);
         rdc(8'h7D, 16'h0000);
         @(posedge sys_clk);
         vout_fault <= 32'h0;
         busy <= 1'b0;
         pg(8'hFF);
         wrc(8'h03, 16'h0000);
         chk("alert released", 16'h0000, {15'h0, host_alert_line_oe});
         pg(8'h02);
         rdc(8'h7B, 16'h0000);
         pg(8'h01);
         rdc(8'h79, 16'h0840);
      end
   endtask
   task t_pins;
      integer n;
      logic [3:0] seen;
      begin
         wrc(8'hD5, 16'h0001);
         wrc(8'hD6, 16'h0002);
         seen = 4'h0;
         // Two lows just short of qualifying; the timer must restart between them
         repeat (2) begin
            @(posedge sys_clk);
            pull_req <= 2'h1;
            repeat (390) begin
               @(negedge sys_clk);
               seen = seen | chan_pin_shutdown;
            end
            @(posedge sys_clk);
            pull_req <= 2'h0;
            repeat (4) @(posedge sys_clk);
         end
         chk("short low", 16'h0000, {12'h0, seen});
         @(posedge sys_clk);
         pull_req <= 2'h3;
         n = 0;
         while (chan_pin_shutdown === 4'h0 && n < 450) begin
            @(negedge sys_clk);
            n = n + 1;
         end
         chk("qual time", 16'h0001, {15'h0, n >= 398 && n <= 408});
         chk("shutdown", 16'h0003, {12'h0, chan_pin_shutdown});
         chk("alert pin", 16'h0001, {15'h0, host_alert_line_oe});
         chk("alert wire", 16'h0000, {15'h0, host_alert_line_in_n});
         pg(8'h00);
         rdc(8'h80, 16'h0001);
         pg(8'h01);
         rdc(8'h80, 16'h0002);
         pg(8'hFF);
         wrc(8'h03, 16'h0000);
         chk("held off", 16'h0003, {12'h0, chan_pin_shutdown});
         chk("alert held", 16'h0001, {15'h0, host_alert_line_oe});
         rdc(8'h80, 16'h0001);
         @(posedge sys_clk);
         pull_req <= 2'h0;
         seen = 4'h0;
         repeat (8) begin
            @(negedge sys_clk);
            seen = seen | chan_restart_ff;
         end
         chk("restart", 16'h0003, {12'h0, seen});
         chk("released", 16'h0000, {12'h0, chan_pin_shutdown});
         wrc(8'h03, 16'h0000);
         chk("alert clear", 16'h0000, {15'h0, host_alert_line_oe});
         pg(8'h00);
         rdc(8'h80, 16'h0000);
      end
   endtask
   // ==========================================================
   // Verdict, watchdog and main sequence
   task report_and_stop;
      begin
         if (miscompares == 0 && check_count > 0) begin
            $display("TEST PASSED");
         end else begin
            $display("TEST FAILED");
         end
         $finish;
      end
   endtask
   // Whole run is near 1300 cycles; over four times that means a hang
   initial begin
      repeat (6000) @(posedge sys_clk);
      miscompares = miscompares + 1;
      report_and_stop;
   end
   initial begin
      repeat (5) @(posedge sys_clk);
      rst <= 1'b0;
      t_select;
      t_status;
      t_pins;
      report_and_stop;
   end
endmodule // tb
bind fspr_top fspr_props u_props (.sys_clk, .rst, .shared_fault_pin_0_n, .shared_fault_pin_1_n,
   .host_alert_line_oe, .cmd_valid, .cmd_write, .cmd_code, .cmd_done_ff, .cmd_err_ff,
   .cmd_rdata_ff, .chan_pin_shutdown, .chan_restart_ff);
